// *** common/afe_trim_defines.vh ***
`ifndef AFE_TRIM_DEFINES_VH
`define AFE_TRIM_DEFINES_VH

// ****************************************
// Register addresses
// ****************************************
`define ADDR_W 8
`define ADDR_POWER_SWITCH 8'h03
`define ADDR_BALANCE_CTRL 8'h04
`define ADDR_CELL6_TRIM 8'h16
`define ADDR_CELL1_2_MSBS 8'h17
`define ADDR_CELL3_6_MSBS 8'h18
`define ADDR_REF_MSBS 8'h1B

// ****************************************
// Field positions
// ****************************************
`define POWER_SLEEP_BIT 0
`define POWER_ARMED_BIT 6
`define CELL6_OFFSET_MSB 7
`define CELL6_OFFSET_LSB 4
`define CELL6_GAIN_MSB 3
`define CELL6_GAIN_LSB 0
`define REF_OFFSET5_BIT 2
`define REF_OFFSET4_BIT 1
`define REF_GAIN4_BIT 0

// ****************************************
// Reset values and cell count
// ****************************************
`define POWER_RESET 8'h00
`define BALANCE_RESET 6'h00
`define RDATA_RESET 8'h00
`define NUM_CELLS 6

`endif

// *** logic/afe_trim_store_and_balance_guard.v ***
`include "afe_trim_defines.vh"

// Behaviour
// - Cell-6 trim at 0x16 gives offset low bits 7:4, gain low bits 3:0.
// - Register 0x17 holds cell1 offset, cell1 gain, cell2 offset, cell2 gain MSBs in 7:4.
// - Register 0x18 holds offset/gain MSB pairs for cells 3 to 6, bits 7 to 0.
// - Register 0x1B holds reference offset bit5, bit4, gain MSB in bits 2:0.
// - Writing the sleep bit moves the device into shutdown.
// - Sleep bit requests sleep when written one; resets to zero.
// - Wake circuit stays disarmed and shutdown holds until regulator rail reaches zero.
// - Once armed, a high wake pin ends shutdown.
// - Balancing switches follow host control directly, never self duty-cycled.
// - Adjacent balancing requests both on force both switches off.
module afe_trim_store_and_balance_guard #(
   parameter [3:0] CELL6_OFFSET_LOW = 4'h0,
   parameter [3:0] CELL6_GAIN_LOW = 4'h0,
   parameter [7:0] CELL1_2_MSBS = 8'h00,
   parameter [7:0] CELL3_6_MSBS = 8'h00,
   parameter [2:0] REF_MSBS = 3'h0,
   parameter NUM_CELLS = `NUM_CELLS
) (
   input wire ref_clk,
   input wire nrst,
   input wire [`ADDR_W-1:0] reg_addr,
   input wire reg_wr_en,
   input wire [7:0] reg_wdata,
   input wire reg_rd_en,
   output reg [7:0] reg_rdata_ff,
   input wire rail_at_zero,
   input wire wake_pin,
   output reg shutdown_ff,
   output reg wake_armed_ff,
   output reg [NUM_CELLS-1:0] balance_switch_ff
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   wire rail_zero_sync;
   wire wake_sync;

   sync_two_flop u_sync_rail (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .async_in(rail_at_zero),
      .sync_out(rail_zero_sync)
   );

   sync_two_flop u_sync_wake (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .async_in(wake_pin),
      .sync_out(wake_sync)
   );

   // ****************************************
   // Fixed trim images
   // ****************************************
   // Built from parameters, so no reset or sleep can disturb them
   wire [7:0] cell6_trim;
   wire [7:0] cell1_2_trim_msbs;
   wire [7:0] cell3_6_trim_msbs;
   wire [7:0] reference_trim_msbs;
   wire cell6_offset_top_bit;
   wire cell6_gain_top_bit;

   assign cell6_trim = {CELL6_OFFSET_LOW, CELL6_GAIN_LOW};
   assign cell1_2_trim_msbs = {CELL1_2_MSBS[7:4], 4'h0};
   assign cell6_offset_top_bit = CELL3_6_MSBS[1];
   assign cell6_gain_top_bit = CELL3_6_MSBS[0];
   assign cell3_6_trim_msbs = {CELL3_6_MSBS[7:2], cell6_offset_top_bit, cell6_gain_top_bit};
   assign reference_trim_msbs = {5'h00, REF_MSBS};

   // ****************************************
   // Control registers
   // ****************************************
   reg [NUM_CELLS-1:0] balance_req_ff;
   reg [NUM_CELLS-1:0] nxt_balance_req;
   reg [NUM_CELLS-1:0] nxt_balance_switch;
   reg nxt_shutdown;
   reg nxt_wake_armed;
   reg [7:0] nxt_rdata;
   integer i;

   wire sleep_write;
   assign sleep_write = reg_wr_en && (reg_addr == `ADDR_POWER_SWITCH) &&
      reg_wdata[`POWER_SLEEP_BIT];

   // Neighbour on either side vetoes this switch
   function blocked;
      input [NUM_CELLS-1:0] req;
      input integer idx;
      begin
         blocked = 1'b0;
         if (idx > 0 && req[idx-1])
            blocked = 1'b1;
         if (idx < NUM_CELLS-1 && req[idx+1])
            blocked = 1'b1;
      end
   endfunction

   always @* begin
      nxt_balance_req = balance_req_ff;
      if (reg_wr_en && (reg_addr == `ADDR_BALANCE_CTRL)) begin
         nxt_balance_req = reg_wdata[NUM_CELLS-1:0];
      end
      nxt_balance_switch = {NUM_CELLS{1'b0}};
      for (i = 0; i < NUM_CELLS; i = i + 1) begin
         // Direct follow of the request, no internal timing of its own
         nxt_balance_switch[i] = nxt_balance_req[i] && !blocked(nxt_balance_req, i);
      end
      // Switches held off in shutdown; requests survive for the wake
      if (nxt_shutdown)
         nxt_balance_switch = {NUM_CELLS{1'b0}};
   end

   // ****************************************
   // Sleep and wake sequence
   // ****************************************
   always @* begin
      nxt_shutdown = shutdown_ff;
      nxt_wake_armed = wake_armed_ff;
      if (!shutdown_ff) begin
         if (sleep_write) begin
            nxt_shutdown = 1'b1;
            nxt_wake_armed = 1'b0;
         end
      end else if (!wake_armed_ff) begin
         // Wake ignored until the rail has drained fully
         if (rail_zero_sync)
            nxt_wake_armed = 1'b1;
      end else if (wake_sync) begin
         nxt_shutdown = 1'b0;
         nxt_wake_armed = 1'b0;
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   always @* begin
      nxt_rdata = reg_rdata_ff;
      if (reg_rd_en) begin
         if (reg_addr == `ADDR_CELL6_TRIM) begin
            nxt_rdata = cell6_trim;
         end else if (reg_addr == `ADDR_CELL1_2_MSBS) begin
            nxt_rdata = cell1_2_trim_msbs;
         end else if (reg_addr == `ADDR_CELL3_6_MSBS) begin
            nxt_rdata = cell3_6_trim_msbs;
         end else if (reg_addr == `ADDR_REF_MSBS) begin
            nxt_rdata = reference_trim_msbs;
         end else if (reg_addr == `ADDR_POWER_SWITCH) begin
            nxt_rdata = 8'h00;
            nxt_rdata[`POWER_SLEEP_BIT] = shutdown_ff;
            nxt_rdata[`POWER_ARMED_BIT] = wake_armed_ff;
         end else if (reg_addr == `ADDR_BALANCE_CTRL) begin
            nxt_rdata = 8'h00;
            nxt_rdata[NUM_CELLS-1:0] = balance_req_ff;
         end else begin
            nxt_rdata = 8'h00;
         end
      end
   end

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         shutdown_ff <= 1'b0;
         wake_armed_ff <= 1'b0;
         balance_req_ff <= `BALANCE_RESET;
         balance_switch_ff <= `BALANCE_RESET;
         reg_rdata_ff <= `RDATA_RESET;
      end else begin
         shutdown_ff <= nxt_shutdown;
         wake_armed_ff <= nxt_wake_armed;
         balance_req_ff <= nxt_balance_req;
         balance_switch_ff <= nxt_balance_switch;
         reg_rdata_ff <= nxt_rdata;
      end
   end

endmodule // afe_trim_store_and_balance_guard

// *** logic/sync_two_flop.v ***
module sync_two_flop (
   input wire ref_clk,
   input wire nrst,
   input wire async_in,
   output wire sync_out
);

   reg stage1_ff;
   reg stage2_ff;

   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         stage1_ff <= 1'b0;
         stage2_ff <= 1'b0;
      end else begin
         stage1_ff <= async_in;
         stage2_ff <= stage1_ff;
      end
   end

   assign sync_out = stage2_ff;

endmodule // sync_two_flop

// *** verif/afe_guard_sva.sv ***
module afe_guard_sva #(parameter NUM_CELLS = 6) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_rdata_ff,
   input wire logic rail_at_zero,
   input wire logic wake_pin,
   input wire logic shutdown_ff,
   input wire logic wake_armed_ff,
   input wire logic [NUM_CELLS-1:0] balance_switch_ff
);
   // ****
   // Checks
   // ****
   logic [5:0] keep;
   assign keep = reg_wdata[5:0] & ~{reg_wdata[4:0], 1'b0} & ~{1'b0, reg_wdata[5:1]};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence sleep_wr;
      reg_wr_en && reg_addr == 8'h03 && reg_wdata[0] && !shutdown_ff;
   endsequence
   sequence wake_held;
      (wake_armed_ff && wake_pin) [*3];
   endsequence
   a_sleep_enters: assert property (sleep_wr |=> shutdown_ff) else $error("no shutdown");
   a_shut_holds: assert property (shutdown_ff && !wake_armed_ff |=> shutdown_ff) else $error("early exit");
   a_arm_rail: assert property ($rose(wake_armed_ff) |-> $past(rail_at_zero, 3)) else $error("armed early");
   a_wake_exit: assert property (wake_held |=> !shutdown_ff) else $error("no wake");
   a_no_adjacent: assert property (!(|(balance_switch_ff & (balance_switch_ff >> 1)))) else $error("adjacent");
   a_shut_bal_off: assert property (shutdown_ff |-> balance_switch_ff == '0) else $error("bal in shutdown");
   a_bal_follow: assert property (reg_wr_en && reg_addr == 8'h04 && !shutdown_ff
      |=> balance_switch_ff == $past(keep)) else $error("bal drive");
   a_rdata_stands: assert property (!reg_rd_en |=> $stable(reg_rdata_ff)) else $error("rdata moved");
endmodule // afe_guard_sva
bind afe_trim_store_and_balance_guard afe_guard_sva #(.NUM_CELLS(NUM_CELLS)) sva_u (.ref_clk(ref_clk),
   .nrst(nrst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
   .reg_rdata_ff(reg_rdata_ff), .rail_at_zero(rail_at_zero), .wake_pin(wake_pin), .shutdown_ff(shutdown_ff),
   .wake_armed_ff(wake_armed_ff), .balance_switch_ff(balance_switch_ff));

// *** verif/afe_trim_store_and_balance_guard_tb.sv ***
module afe_trim_store_and_balance_guard_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] addr, wdata, rdata, got;
   logic wr_en, rd_en, rail, wake, shut, armed;
   logic [5:0] bal;
   int err_count = 0;
   int checks_done = 0;
   logic [7:0] adr_t [5] = '{8'h16, 8'h17, 8'h18, 8'h1B, 8'h22};
   logic [7:0] exp_t [5] = '{8'hA5, 8'hB0, 8'h96, 8'h05, 8'h00};
   logic [7:0] bal_in [5] = '{8'h05, 8'h03, 8'h2A, 8'h3F, 8'h21};
   logic [7:0] bal_ex [5] = '{8'h05, 8'h00, 8'h2A, 8'h00, 8'h21};
   initial forever #20 ref_clk = ~ref_clk;
   host_model host_u (.ref_clk(ref_clk), .reg_rdata_ff(rdata), .reg_addr(addr), .reg_wr_en(wr_en),
      .reg_wdata(wdata), .reg_rd_en(rd_en), .rail_at_zero(rail), .wake_pin(wake));
   afe_trim_store_and_balance_guard #(.CELL6_OFFSET_LOW(4'hA), .CELL6_GAIN_LOW(4'h5), .CELL1_2_MSBS(8'hB0),
      .CELL3_6_MSBS(8'h96), .REF_MSBS(3'h5)) dut_u (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(addr),
      .reg_wr_en(wr_en), .reg_wdata(wdata), .reg_rd_en(rd_en), .reg_rdata_ff(rdata), .rail_at_zero(rail),
      .wake_pin(wake), .shutdown_ff(shut), .wake_armed_ff(armed), .balance_switch_ff(bal));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic end_sim();
      if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #100us;
      err_count++;
      end_sim();
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk) nrst = 1'b1;
      host_u.rd(8'h03, got);
      chk(got, 8'h00);
      for (int i = 0; i < 5; i++) begin
         host_u.wr(adr_t[i], 8'hFF);
         host_u.rd(adr_t[i], got);
         chk(got, exp_t[i]);
      end
      for (int i = 0; i < 5; i++) begin
         host_u.wr(8'h04, bal_in[i]);
         chk({2'b00, bal}, bal_ex[i]);
      end
      host_u.rd(8'h04, got);
      chk(got, 8'h21);
      // Power writes with the sleep bit clear leave the device running
      host_u.wr(8'h03, 8'hFE);
      chk({shut, armed, bal}, 8'h21);
      host_u.wr(8'h03, 8'h01);
      chk({shut, armed, bal}, 8'h80);
      // Wake before the rail drains must be ignored
      host_u.pins(1'b0, 1'b1);
      repeat (10) @(negedge ref_clk);
      chk({shut, armed, bal}, 8'h80);
      host_u.pins(1'b1, 1'b0);
      for (int n = 0; n < 20 && armed !== 1'b1; n++) @(negedge ref_clk);
      chk({shut, armed, bal}, 8'hC0);
      host_u.rd(8'h03, got);
      chk(got, 8'h41);
      host_u.pins(1'b1, 1'b1);
      for (int n = 0; n < 20 && shut !== 1'b0; n++) @(negedge ref_clk);
      chk({shut, armed, bal}, 8'h21);
      host_u.pins(1'b0, 1'b0);
      host_u.rd(8'h03, got);
      chk(got, 8'h00);
      // Balancing off before the reset and cell-6 trim readback
      host_u.wr(8'h04, 8'h00);
      chk({2'b00, bal}, 8'h00);
      @(negedge ref_clk) nrst = 1'b0;
      @(negedge ref_clk) nrst = 1'b1;
      host_u.rd(8'h16, got);
      chk(got, 8'hA5);
      end_sim();
   end
endmodule // afe_trim_store_and_balance_guard_tb

// *** verif/host_model.sv ***
module host_model (
   input wire logic ref_clk,
   input wire logic [7:0] reg_rdata_ff,
   output logic [7:0] reg_addr,
   output logic reg_wr_en,
   output logic [7:0] reg_wdata,
   output logic reg_rd_en,
   output logic rail_at_zero,
   output logic wake_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {reg_addr, reg_wr_en, reg_wdata, reg_rd_en, rail_at_zero, wake_pin} = '0;
   // Data flipped after use so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      @(negedge ref_clk);
      reg_wr_en = 1'b0;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(negedge ref_clk);
      reg_rd_en = 1'b0;
      d = reg_rdata_ff;
   endtask
   task automatic pins(input logic r, input logic w);
      @(negedge ref_clk);
      rail_at_zero = r;
      wake_pin = w;
   endtask
endmodule // host_model
